/* hw/pmic_serial_ctrl.sv */
/*
  Two-wire serial slave with register pointer, power good sense, dual-edge event latching and
  off-mode register reset. Assumes bus pins and source levels are asynchronous to the core
  clock, and that bus clock edges are spaced by many core clock periods.
*/
`timescale 1ns/10ps
`include "pmic_defs.svh"
module pmic_serial_ctrl #(
  parameter logic [6:0]  DEV_ADDR     = `DEV_ADDR_A,
  parameter int unsigned BLANK_CYCLES = `BLANK_CYCLES,
  parameter int unsigned PG_CYCLES    = `PG_CYCLES,
  parameter int unsigned IDLE_CYCLES  = `IDLE_CYCLES
) (
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_hw_enable_pin,
  input  wire logic i_undervoltage_lockout_event,
  input  wire logic i_power_up_sequence_done,
  input  wire logic i_thermal_warning,
  input  wire logic i_thermal_shutdown,
  output logic      o_sda_o,
  output logic      o_sda_oe,
  output logic      o_power_good_sense,
  output logic      o_off_mode
);

  // --------------------------------------------------------------------------
  // State and helpers
  // --------------------------------------------------------------------------
  localparam logic [19:0] BLANK_END = `CNT_W'(BLANK_CYCLES);
  localparam logic [19:0] PG_END    = `CNT_W'(PG_CYCLES - 1);
  localparam logic [19:0] IDLE_END  = `CNT_W'(IDLE_CYCLES);

  pmic_pkg::core_st_t st_r;
  pmic_pkg::core_st_t st_nxt;
  logic [7:0]         mem_rdata;
  logic [6:0]         pins;
  logic [3:0]         src;
  logic [3:0]         src_edge;
  logic               pg_set;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_c;
  logic               stop_c;
  logic [7:0]         rd_byte;

  // Only the second synchroniser stage and its delayed copy feed logic
  assign pins     = {i_thermal_shutdown, i_thermal_warning, i_power_up_sequence_done,
                     i_undervoltage_lockout_event, i_hw_enable_pin, i_sda, i_scl};
  assign src      = st_r.pin_s2[`PIN_SRC_HI:`PIN_SRC_LO];
  assign src_edge = src ^ st_r.pin_d[`PIN_SRC_HI:`PIN_SRC_LO];
  assign scl_rise = st_r.pin_s2[`PIN_SCL] & ~st_r.pin_d[`PIN_SCL];
  assign scl_fall = ~st_r.pin_s2[`PIN_SCL] & st_r.pin_d[`PIN_SCL];
  assign start_c  = st_r.pin_s2[`PIN_SCL] & st_r.pin_d[`PIN_SCL] &
                    ~st_r.pin_s2[`PIN_SDA] & st_r.pin_d[`PIN_SDA];
  assign stop_c   = st_r.pin_s2[`PIN_SCL] & st_r.pin_d[`PIN_SCL] &
                    st_r.pin_s2[`PIN_SDA] & ~st_r.pin_d[`PIN_SDA];
  // Rising power good worked out from registered state, keeping the next-state logic loop free
  assign pg_set   = ~st_r.pg & ~st_r.off & src[`SRC_PUS] & (st_r.pg_cnt == PG_END);

  // --------------------------------------------------------------------------
  // Read data selection
  // --------------------------------------------------------------------------
  // Addresses above the storage are reserved: no storage, read as zero
  always_comb begin
    case (st_r.ptr)
      `REG_POLICY: rd_byte = st_r.policy;
      `REG_LIVE:   rd_byte = {3'h0, st_r.pg, src};
      `REG_LATCH:  rd_byte = {3'h0, st_r.lat};
      default:     rd_byte = (st_r.ptr <= `STORE_TOP) ? mem_rdata : 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic clr;
    logic load;
    clr           = 1'b0;
    load          = 1'b0;
    st_nxt        = st_r;
    st_nxt.pin_s1 = pins;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.pin_d  = st_r.pin_s2;
    st_nxt.mem_wr = '0;
    st_nxt.sda_o  = 1'b0;

    // Blanking restarts only at undervoltage, so idle-off never blocks a host
    if (src[`SRC_UNDERVOLTAGE_LOCKOUT_EVENT]) begin
      st_nxt.blank_cnt = '0;
    end else if (st_r.blank_cnt != BLANK_END) begin
      st_nxt.blank_cnt = st_r.blank_cnt + 20'h1;
    end

    // Bus idle timer for the absent-host condition
    if (st_r.pin_s2[1:0] != st_r.pin_d[1:0]) begin
      st_nxt.idle_cnt = '0;
    end else if (st_r.idle_cnt != IDLE_END) begin
      st_nxt.idle_cnt = st_r.idle_cnt + 20'h1;
    end

    // Off mode conditions
    st_nxt.off = src[`SRC_UNDERVOLTAGE_LOCKOUT_EVENT] |
                 ((st_r.idle_cnt == IDLE_END) & ~st_r.pin_s2[`PIN_HW_ENABLE_PIN]) |
                 (src_edge[`SRC_TSD] & ~src[`SRC_TSD] &
                  (st_r.policy[`POLICY_HI:`POLICY_LO] == `POLICY_RESTART));

    // Power good sense held low through the sequence plus the delay
    if (st_r.off || !src[`SRC_PUS]) begin
      st_nxt.pg     = 1'b0;
      st_nxt.pg_cnt = '0;
    end else if (st_r.pg_cnt == PG_END) begin
      st_nxt.pg     = 1'b1;
    end else begin
      st_nxt.pg_cnt = st_r.pg_cnt + 20'h1;
    end

    // Serial protocol
    case (st_r.fsm)
      pmic_pkg::ST_IDLE: begin
        st_nxt.oe = 1'b0;
      end
      pmic_pkg::ST_ADDR: begin
        if (scl_rise) begin
          st_nxt.shreg  = {st_r.shreg[6:0], st_r.pin_s2[`PIN_SDA]};
          st_nxt.bitcnt = st_r.bitcnt + 4'h1;
        end else if (scl_fall && st_r.bitcnt == 4'h8) begin
          // Wrong address or blanking: stay released, which the master sees as a NACK
          if (st_r.shreg[7:1] == DEV_ADDR && st_r.blank_cnt == BLANK_END) begin
            st_nxt.oe  = 1'b1;
            st_nxt.rw  = st_r.shreg[0];
            st_nxt.fsm = pmic_pkg::ST_ADDR_ACK;
          end else begin
            st_nxt.fsm = pmic_pkg::ST_IDLE;
          end
        end
      end
      pmic_pkg::ST_ADDR_ACK: begin
        if (scl_fall) begin
          st_nxt.oe        = 1'b0;
          st_nxt.bitcnt    = '0;
          st_nxt.ptr_phase = 1'b1;
          if (st_r.rw) begin
            load       = 1'b1;
          end else begin
            st_nxt.fsm = pmic_pkg::ST_WR_BYTE;
          end
        end
      end
      pmic_pkg::ST_WR_BYTE: begin
        if (scl_rise) begin
          st_nxt.shreg  = {st_r.shreg[6:0], st_r.pin_s2[`PIN_SDA]};
          st_nxt.bitcnt = st_r.bitcnt + 4'h1;
        end else if (scl_fall && st_r.bitcnt == 4'h8) begin
          st_nxt.oe     = 1'b1;
          st_nxt.bitcnt = '0;
          st_nxt.fsm    = pmic_pkg::ST_WR_ACK;
          if (st_r.ptr_phase) begin
            st_nxt.ptr       = st_r.shreg;
            st_nxt.ptr_phase = 1'b0;
          end else begin
            st_nxt.ptr = st_r.ptr + 8'h1;
            if (st_r.ptr == `REG_POLICY) begin
              st_nxt.policy = st_r.shreg;
            end else if (st_r.ptr <= `STORE_TOP && st_r.ptr != `REG_LIVE && st_r.ptr != `REG_LATCH) begin
              st_nxt.mem_wr = '{we: 1'b1, addr: st_r.ptr[4:0], data: st_r.shreg};
            end
          end
        end
      end
      pmic_pkg::ST_WR_ACK: begin
        if (scl_fall) begin
          st_nxt.oe  = 1'b0;
          st_nxt.fsm = pmic_pkg::ST_WR_BYTE;
        end
      end
      pmic_pkg::ST_RD_BYTE: begin
        if (scl_fall) begin
          if (st_r.bitcnt == 4'h7) begin
            st_nxt.oe  = 1'b0;
            st_nxt.ptr = st_r.ptr + 8'h1;
            st_nxt.fsm = pmic_pkg::ST_RD_ACK;
          end else begin
            st_nxt.shreg  = {st_r.shreg[6:0], 1'b0};
            st_nxt.oe     = ~st_r.shreg[6];
            st_nxt.bitcnt = st_r.bitcnt + 4'h1;
          end
        end
      end
      pmic_pkg::ST_RD_ACK: begin
        if (scl_rise) begin
          st_nxt.ack_ok = ~st_r.pin_s2[`PIN_SDA];
        end else if (scl_fall) begin
          if (st_r.ack_ok) begin
            load       = 1'b1;
          end else begin
            st_nxt.fsm = pmic_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        st_nxt.oe  = 1'b0;
        st_nxt.fsm = pmic_pkg::ST_IDLE;
      end
    endcase

    // Launch a read byte; open drain drives low for a zero bit
    if (load) begin
      st_nxt.shreg  = rd_byte;
      st_nxt.oe     = ~rd_byte[7];
      st_nxt.bitcnt = '0;
      st_nxt.fsm    = pmic_pkg::ST_RD_BYTE;
      clr           = (st_r.ptr == `REG_LATCH);
    end

    // Start and stop override any byte in progress
    if (start_c) begin
      st_nxt.fsm    = pmic_pkg::ST_ADDR;
      st_nxt.bitcnt = '0;
      st_nxt.oe     = 1'b0;
    end else if (stop_c) begin
      st_nxt.fsm = pmic_pkg::ST_IDLE;
      st_nxt.oe  = 1'b0;
    end

    // Event latch: clears first, new events last so a coinciding edge survives
    st_nxt.rd_clr = clr;
    if (clr || st_r.off) begin
      st_nxt.lat = '0;
    end
    if (!st_r.pin_s2[`PIN_HW_ENABLE_PIN]) begin
      st_nxt.lat[`EVT_PG] = 1'b0;
    end
    st_nxt.lat = st_nxt.lat | {pg_set, src_edge};

    // Off-mode policy reset after the protocol, so a write landing together loses
    if (st_r.off) begin
      st_nxt.policy = `POLICY_RST;
    end

    // Internal update of the modify-type register
    if (src_edge[`SRC_TSD] && src[`SRC_TSD]) begin
      st_nxt.policy[`POLICY_TSD_SEEN] = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r        <= '0;
      st_r.policy <= `POLICY_RST;
      st_r.pin_s1 <= `PIN_IDLE;
      st_r.pin_s2 <= `PIN_IDLE;
      st_r.pin_d  <= `PIN_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  pmic_regfile u_regfile (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_clear    (st_r.off),
    .i_wr       (st_r.mem_wr),
    .i_raddr    (st_r.ptr[4:0]),
    .o_rdata    (mem_rdata)
  );

  assign o_sda_o            = st_r.sda_o;
  assign o_sda_oe           = st_r.oe;
  assign o_power_good_sense = st_r.pg;
  assign o_off_mode         = st_r.off;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // Helper: no new event arrives in the cycle a read clear lands
  logic clr_quiet;
  assign clr_quiet = (src_edge == 4'h0) && !pg_set;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  a_pg_after_off:  assert property (st_r.off |=> !st_r.pg) else $error("pg sense high after off");
  a_pg_delay:      assert property ($rose(st_r.pg) |-> $past(st_r.pg_cnt) == PG_END)
                     else $error("pg sense rose early");
  a_pg_event:      assert property ($rose(st_r.pg) |-> st_r.lat[`EVT_PG]) else $error("pg event missing");
  a_edge_latch:    assert property (src_edge != 4'h0 |=>
                     (st_r.lat[3:0] & $past(src_edge)) == $past(src_edge))
                     else $error("source edge not latched");
  a_read_clear:    assert property (clr_quiet && st_r.fsm == pmic_pkg::ST_RD_ACK && scl_fall
                     && st_r.ack_ok && st_r.ptr == `REG_LATCH |=> st_r.lat == 5'h00)
                     else $error("latch not cleared");
  a_off_default:   assert property (st_r.off && !(src_edge[`SRC_TSD] && src[`SRC_TSD]) |=>
                     st_r.policy == `POLICY_RST)
                     else $error("policy not reset");
  a_addr_ack:      assert property ($rose(st_r.fsm == pmic_pkg::ST_ADDR_ACK) |->
                     $past(st_r.shreg[7:1]) == DEV_ADDR && $past(st_r.blank_cnt) == BLANK_END)
                     else $error("ack on wrong address or blanking");
  a_ack_drive:     assert property (st_r.fsm inside {pmic_pkg::ST_ADDR_ACK, pmic_pkg::ST_WR_ACK} |-> st_r.oe)
                     else $error("ack not driven");
  a_wr_ptr:        assert property (st_r.mem_wr.we |-> st_r.ptr == $past(st_r.ptr) + 8'h1)
                     else $error("pointer not advanced on write");
  a_rd_release:    assert property ($rose(st_r.fsm == pmic_pkg::ST_RD_ACK) |->
                     !st_r.oe && st_r.ptr == $past(st_r.ptr) + 8'h1)
                     else $error("read ack phase wrong");

  c_write:  cover property (st_r.mem_wr.we);
  c_read:   cover property (st_r.fsm == pmic_pkg::ST_RD_ACK && st_r.ack_ok);
  c_pg:     cover property ($rose(st_r.pg));
  c_off:    cover property ($rose(st_r.off));

endmodule

/* include/pmic_defs.svh */
/*
  Constants of the serial control and event block: register offsets, field positions,
  reset values, bus address and timing counts. Assumes a 100 MHz core clock.
*/
// Function
// - Power good sense stays low, then delay
// - Power good rise latches event, read clears
// - Both edges of every source raise events
// - Four sources: undervoltage, sequence done, thermal
// - Latched event register, cleared when read
// - Live event register shows sources unlatched
// - Off mode returns registers to defaults
// - First byte: address, low bit read/write
// - Write: pointer byte, then incrementing data
// - Read starts at pointer, increments per byte
// - Seven bit address only, fixed per variant
// - Modify-type registers also updated internally
// - Not acknowledge during early bias blanking
`ifndef PMIC_DEFS_SVH
`define PMIC_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS      10
`define BLANK_TIME_NS      50000
`define BLANK_CYCLES       ((`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIG_CLK_PERIOD_NS  8000
`define PG_DIG_CLKS        16
`define PG_CYCLES          ((`PG_DIG_CLKS * `DIG_CLK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE_TIME_NS       1000000
`define IDLE_CYCLES        (`IDLE_TIME_NS / `CLK_PERIOD_NS)
`define CNT_W              20

// ----------------------------------------------------------------------------
// Bus address and synchronised pin positions
// ----------------------------------------------------------------------------
`define DEV_ADDR_A         7'h10
`define DEV_ADDR_B         7'h18
`define PIN_SCL            0
`define PIN_SDA            1
`define PIN_HW_ENABLE_PIN           2
`define PIN_SRC_LO         3
`define PIN_SRC_HI         6
`define PIN_IDLE           7'h03 // Bus lines idle high on pull-ups, enable idles low
`define SRC_UNDERVOLTAGE_LOCKOUT_EVENT           0
`define SRC_PUS            1
`define SRC_TSD            3
`define EVT_PG             4
`define POLICY_HI          7
`define POLICY_LO          6

// ----------------------------------------------------------------------------
// Register map and reset values
// ----------------------------------------------------------------------------
`define REG_GENERAL        8'h00
`define REG_LINEAR1        8'h01
`define REG_POLICY         8'h09
`define REG_LIVE           8'h0A
`define REG_LATCH          8'h0B
`define STORE_TOP          8'h1F
`define GENERAL_RST        8'h00
`define LINEAR1_RST        8'h39
`define POLICY_RST         8'h00
`define POLICY_RESTART     2'b00
`define POLICY_TSD_SEEN    0

`endif

/* include/pmic_pkg.sv */
/*
  Types of the serial control and event block: controller states and packed state records.
  Assumes nothing beyond the constants header.
*/
package pmic_pkg;

  // --------------------------------------------------------------------------
  // Serial controller states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK
  } ctrl_state_t;

  // Write request to the register storage
  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [7:0] data;
  } mem_wr_t;

  // Storage state
  typedef struct packed {
    logic [31:0][7:0] mem;
    logic [7:0]       rdata;
  } mem_st_t;

  // Whole state of the controller
  typedef struct packed {
    logic [6:0]  pin_s1;
    logic [6:0]  pin_s2;
    logic [6:0]  pin_d;
    ctrl_state_t fsm;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic        rw;
    logic        ptr_phase;
    logic        ack_ok;
    logic [7:0]  ptr;
    logic        oe;
    logic        sda_o;
    logic [4:0]  lat;
    logic        pg;
    logic [19:0] pg_cnt;
    logic [19:0] blank_cnt;
    logic [19:0] idle_cnt;
    logic [7:0]  policy;
    logic        off;
    logic        rd_clr;
    mem_wr_t     mem_wr;
  } core_st_t;

endpackage

/* hw/pmic_regfile.sv */
/*
  Byte storage of the host-writable registers, one write port and a registered read port.
  Assumes the controller holds the read address steady for a cycle before using the data.
*/
`timescale 1ns/10ps
`include "pmic_defs.svh"
module pmic_regfile (
  input  wire logic            i_core_clk,
  input  wire logic            i_resetn,
  input  wire logic            i_clear,
  input  wire pmic_pkg::mem_wr_t i_wr,
  input  wire logic [4:0]      i_raddr,
  output logic [7:0]           o_rdata
);

  // --------------------------------------------------------------------------
  // Defaults per entry
  // --------------------------------------------------------------------------
  wire logic [31:0][7:0] dflt;
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_dflt
      assign dflt[g] = (g == `REG_GENERAL) ? `GENERAL_RST :
                       (g == `REG_LINEAR1) ? `LINEAR1_RST : 8'h00;
    end
  endgenerate

  pmic_pkg::mem_st_t st_r;
  pmic_pkg::mem_st_t st_nxt;

  // Clear beats a write so off mode always lands on defaults
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = st_r.mem[i_raddr];
    if (i_clear) begin
      st_nxt.mem = dflt;
    end else if (i_wr.we) begin
      st_nxt.mem[i_wr.addr] = i_wr.data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
      st_r.mem[`REG_LINEAR1] <= `LINEAR1_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata;

endmodule

/* tb/pmic_host_model.sv */
/*
  Bus master model for the two-wire port: start, stop, byte send and receive.
  Assumes a pull-up on the data line and the core clock as its time base.
*/
`timescale 1ns/10ps
module pmic_host_model (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  logic [7:0] rb [0:3];
  logic       ok;

  // Bus idles with both lines released
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // Step n core cycles, landing just past the edge
  task automatic wt(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  // One bit of 16 core cycles; data moves only while the clock is low
  task automatic bt(input logic low, output logic s);
    wt(1);
    o_sda_low = low;
    wt(7);
    o_scl = 1'b1;
    wt(8);
    s = i_sda;
    o_scl = 1'b0;
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic st();
    wt(1);
    o_sda_low = 1'b0;
    wt(7);
    o_scl = 1'b1;
    wt(8);
    o_sda_low = 1'b1;
    wt(8);
    o_scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high, clock then stands still
  task automatic sp();
    wt(1);
    o_sda_low = 1'b1;
    wt(7);
    o_scl = 1'b1;
    wt(8);
    o_sda_low = 1'b0;
    wt(8);
  endtask

  // Byte out, most significant bit first, then the device's answer bit
  task automatic tx(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bt(~b[i], s);
    bt(1'b0, s);
    ok = ok & ~s;
  endtask

  // Write: address, pointer, optional data; rs keeps the bus for a repeated start
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input int n,
                    input logic [7:0] d0, input logic [7:0] d1, input logic rs);
    ok = 1'b1;
    st();
    tx({a, 1'b0});
    tx(p);
    if (n > 0) tx(d0);
    if (n > 1) tx(d1);
    if (!rs) sp();
  endtask

  // Read n bytes; the last one is refused so the device lets go
  task automatic rd(input logic [6:0] a, input int n);
    logic s;
    ok = 1'b1;
    st();
    tx({a, 1'b1});
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) begin
        bt(1'b0, s);
        rb[i][k] = s;
      end
      bt(i < n - 1, s);
    end
    sp();
  endtask
endmodule

/* tb/tb_pmic_serial_ctrl.sv */
/*
  Self-checking bench of the serial control and event block.
  Assumes the host model above and shortened blanking, power good and idle counts.
*/
`timescale 1ns/10ps
module tb_pmic_serial_ctrl;
  localparam int unsigned BLANK = 400;
  localparam int unsigned IDLE  = 2000;
  localparam logic [6:0]  ADR   = 7'h10;
  logic i_core_clk, i_resetn, scl, sda_low, sda, hw_enable_pin, undervoltage_lockout_event, power_up_sequence_done, warn, thermal_shutdown;
  logic sda_o, sda_oe, pg, off, off_seen;
  int   n_mismatch, num_checks, cyc;

  // Open-drain data line with pull-up
  assign sda = !(sda_low || (sda_oe && !sda_o));

  pmic_serial_ctrl #(.DEV_ADDR(ADR), .BLANK_CYCLES(BLANK), .PG_CYCLES(16), .IDLE_CYCLES(IDLE)) dut (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda), .i_hw_enable_pin(hw_enable_pin),
    .i_undervoltage_lockout_event(undervoltage_lockout_event), .i_power_up_sequence_done(power_up_sequence_done), .i_thermal_warning(warn),
    .i_thermal_shutdown(thermal_shutdown), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_power_good_sense(pg),
    .o_off_mode(off));

  pmic_host_model m (.i_core_clk(i_core_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  // Clock, hang limit and a sticky record of off mode
  initial i_core_clk = 1'b0;
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc++;
    if (off === 1'b1) off_seen <= 1'b1;
    if (cyc == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    m.wr(ADR, p, 1, d, 8'h00, 1'b0);
    chk({7'h00, m.ok}, 8'h01);
  endtask

  // Pointer write, repeated start, then read
  task automatic rreg(input logic [7:0] p, input int n);
    m.wr(ADR, p, 0, 8'h00, 8'h00, 1'b1);
    chk({7'h00, m.ok}, 8'h01);
    m.rd(ADR, n);
    chk({7'h00, m.ok}, 8'h01);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Stimulus and checks
  // --------------------------------------------------------------------------
  initial begin
    {hw_enable_pin, undervoltage_lockout_event, power_up_sequence_done, warn, thermal_shutdown} = 5'b10000;
    {i_resetn, n_mismatch, num_checks, cyc, off_seen} = '0;
    tick(4);
    i_resetn = 1'b1;
    m.wr(ADR, 8'h10, 1, 8'hA5, 8'h00, 1'b0);
    chk({7'h00, m.ok}, 8'h00);
    tick(BLANK);
    rreg(8'h00, 3);
    chk(m.rb[0], 8'h00);
    chk(m.rb[1], 8'h39);
    done("defaults");
    // Burst across the top of storage into a reserved place
    m.wr(ADR, 8'h1F, 2, 8'h5A, 8'hC3, 1'b0);
    rreg(8'h1E, 3);
    chk(m.rb[0], 8'h00);
    chk(m.rb[1], 8'h5A);
    chk(m.rb[2], 8'h00);
    m.wr(ADR, 8'h10, 2, 8'hA5, 8'h3C, 1'b0);
    m.wr(ADR, 8'h11, 0, 8'h00, 8'h00, 1'b0);
    m.rd(ADR, 1);
    chk(m.rb[0], 8'h3C);
    m.wr(7'h18, 8'h10, 1, 8'hFF, 8'h00, 1'b0);
    chk({7'h00, m.ok}, 8'h00);
    rreg(8'h10, 1);
    chk(m.rb[0], 8'hA5);
    done("access");
    power_up_sequence_done = 1'b1;
    tick(10);
    chk({7'h00, pg}, 8'h00);
    tick(20);
    chk({7'h00, pg}, 8'h01);
    rreg(8'h0B, 1);
    chk(m.rb[0], 8'h12);
    rreg(8'h0B, 1);
    chk(m.rb[0], 8'h00);
    warn = 1'b1;
    tick(10);
    rreg(8'h0A, 2);
    chk(m.rb[0], 8'h16);
    chk(m.rb[1], 8'h04);
    warn = 1'b0;
    tick(10);
    rreg(8'h0A, 2);
    chk(m.rb[0], 8'h12);
    chk(m.rb[1], 8'h04);
    power_up_sequence_done = 1'b0;
    tick(10);
    power_up_sequence_done = 1'b1;
    tick(30);
    hw_enable_pin = 1'b0;
    tick(10);
    hw_enable_pin = 1'b1;
    tick(5);
    rreg(8'h0A, 2);
    chk(m.rb[1], 8'h02);
    done("events");
    // Thermal restart only forces off mode when the policy bits are 00
    wreg(8'h09, 8'h40);
    thermal_shutdown = 1'b1;
    tick(10);
    rreg(8'h09, 1);
    chk(m.rb[0], 8'h41);
    thermal_shutdown = 1'b0;
    tick(10);
    chk({7'h00, off_seen}, 8'h00);
    rreg(8'h0A, 2);
    chk(m.rb[1], 8'h08);
    wreg(8'h09, 8'h00);
    thermal_shutdown = 1'b1;
    tick(10);
    thermal_shutdown = 1'b0;
    tick(10);
    chk({7'h00, off_seen}, 8'h01);
    rreg(8'h10, 1);
    chk(m.rb[0], 8'h00);
    wreg(8'h01, 8'h77);
    undervoltage_lockout_event = 1'b1;
    tick(10);
    chk({7'h00, off}, 8'h01);
    undervoltage_lockout_event = 1'b0;
    tick(BLANK + 10);
    rreg(8'h01, 1);
    chk(m.rb[0], 8'h39);
    wreg(8'h10, 8'h66);
    off_seen = 1'b0;
    hw_enable_pin = 1'b0;
    tick(IDLE + 50);
    hw_enable_pin = 1'b1;
    tick(10);
    chk({7'h00, off_seen}, 8'h01);
    rreg(8'h10, 1);
    chk(m.rb[0], 8'h00);
    done("off mode");
    tally_and_finish();
  end
endmodule
